// File: tcx_cfg.svh
// Constants for the alt-mode crossbar configuration block
`ifndef TCX_CFG_SVH
`define TCX_CFG_SVH
`define TCX_CLK_MHZ 250
`define TCX_CW 22
`define TCX_PG_US 500
`define TCX_HOLD_US 10
`define TCX_DEB_MS 5
`define TCX_RXDET_MS 12
`define TCX_U1_US 100
`define TCX_ADDR_HI_0 5'h11
`define TCX_ADDR_HI_R 5'h08
`define TCX_ADDR_HI_F 5'h04
`define TCX_ADDR_HI_1 5'h03
`define TCX_PG_CYC (`TCX_PG_US * `TCX_CLK_MHZ)
`define TCX_HOLD_CYC (`TCX_HOLD_US * `TCX_CLK_MHZ)
`define TCX_DEB_CYC (`TCX_DEB_MS * 1000 * `TCX_CLK_MHZ)
`define TCX_RXDET_CYC (`TCX_RXDET_MS * 1000 * `TCX_CLK_MHZ)
`define TCX_U1_CYC (`TCX_U1_US * `TCX_CLK_MHZ)
`endif

// File: tcx_pkg.sv
// Types shared by the crossbar configuration block
package tcx_pkg;
  typedef enum logic [1:0] {lv_0, lv_r, lv_f, lv_1} tcx_lvl_t;
  typedef enum logic [1:0] {cfg_off, cfg_usb, cfg_dp4, cfg_usb_dp2} tcx_cfg_t;
  typedef enum logic [2:0] {src_none, src_host_tx, src_lane0, src_lane1, src_lane2, src_lane3} tcx_src_t;
  typedef enum logic [1:0] {hsrc_none, hsrc_rx_a, hsrc_rx_b} tcx_hsrc_t;
  typedef enum logic [1:0] {us_disc, us_u23, us_u1, us_u0} tcx_ustate_t;
  typedef struct packed {
    tcx_src_t  rx_a;
    tcx_src_t  tx_a;
    tcx_src_t  rx_b;
    tcx_src_t  tx_b;
    tcx_hsrc_t host_rx;
  } tcx_route_t;
  typedef struct packed {
    logic pos_a;
    logic pos_b;
    logic neg_a;
    logic neg_b;
  } tcx_sbu_t;
  typedef struct packed {
    logic [3:0]      dfp_a;
    logic [3:0]      dfp_b;
    logic [3:0]      ufp;
    logic [3:0][3:0] lane;
  } tcx_gain_t;
  typedef struct packed {
    logic      usb_select_bit;
    logic      dp_select_bit;
    logic      orientation_bit;
    logic      sideband_override_bit;
    tcx_gain_t gain;
  } tcx_reg_t;
  typedef struct packed {
    logic det_ufp;
    logic det_dfp;
    logic idle_ufp;
    logic idle_dfp;
    logic lfps_ufp;
    logic lfps_dfp;
  } tcx_phy_t;
  typedef struct packed {
    logic term_en;
    logic tx_cm_en;
    logic redrive_en;
    logic det_req;
  } tcx_phyctl_t;
  typedef struct packed {
    tcx_lvl_t host_sel;
    tcx_lvl_t dfp_hi;
    tcx_lvl_t dfp_lo;
    tcx_lvl_t ufp_hi;
    tcx_lvl_t ufp_lo;
    tcx_lvl_t disp_hi;
    tcx_lvl_t disp_lo;
  } tcx_straps_t;
endpackage

// File: tcx_debounce.sv
// Pin synchroniser and debounce filter
`timescale 1ns/100ps
`include "tcx_cfg.svh"
module tcx_debounce #(
  parameter int CW     = `TCX_CW,
  parameter int DB_CYC = `TCX_DEB_CYC
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic pin,
  output logic      level
);
  typedef struct packed {
    logic          s1;
    logic          s2;
    logic          lvl;
    logic [CW-1:0] cnt;
  } tcx_db_st_t;

  tcx_db_st_t st_r;
  tcx_db_st_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = pin;
    st_nxt.s2 = st_r.s1;
    if (st_r.s2 == st_r.lvl)
    begin
      st_nxt.cnt = '0;
    end
    else if (st_r.cnt == CW'(DB_CYC - 1))
    begin
      st_nxt.lvl = st_r.s2;
      st_nxt.cnt = '0;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign level = st_r.lvl;
endmodule

// File: tcx_crossbar_ctl.sv
// Alt-mode crossbar configuration, strap latch and USB link power control
`timescale 1ns/100ps
`include "tcx_cfg.svh"
module tcx_crossbar_ctl #(
  parameter int PG_CYC    = `TCX_PG_CYC,
  parameter int DEB_CYC   = `TCX_DEB_CYC,
  parameter int RXDET_CYC = `TCX_RXDET_CYC,
  parameter int U1_CYC    = `TCX_U1_CYC
) (
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  input  wire logic                 dp_enable_pin,
  input  wire logic                 usb_enable_pin,
  input  wire logic                 orientation_pin,
  input  wire tcx_pkg::tcx_straps_t strap_lvl,
  input  wire tcx_pkg::tcx_reg_t    regs,
  input  wire tcx_pkg::tcx_phy_t    phy_stat,
  output logic                      power_good,
  output logic                      strap_pull_off,
  output logic                      i2c_mode,
  output tcx_pkg::tcx_cfg_t         cfg,
  output logic                      flipped,
  output tcx_pkg::tcx_route_t       route,
  output tcx_pkg::tcx_sbu_t         sbu,
  output tcx_pkg::tcx_gain_t        gain,
  output tcx_pkg::tcx_ustate_t      usb_state,
  output tcx_pkg::tcx_phyctl_t      phyctl,
  output logic [6:0]                target_addr
);
  localparam int CW = `TCX_CW;
  localparam int HOLD_CYC = `TCX_HOLD_CYC;
  // Upper address bits per level of the display lo strap
  localparam logic [3:0][4:0] ADDR_HI = {`TCX_ADDR_HI_1, `TCX_ADDR_HI_F, `TCX_ADDR_HI_R, `TCX_ADDR_HI_0};

  typedef struct packed {
    logic [CW-1:0]        pg_cnt;
    logic                 pg;
    logic [CW-1:0]        hold_cnt;
    logic                 pull_off;
    tcx_pkg::tcx_straps_t sp1;
    tcx_pkg::tcx_straps_t sp2;
    tcx_pkg::tcx_straps_t strap;
    tcx_pkg::tcx_phy_t    ph1;
    tcx_pkg::tcx_phy_t    ph2;
    logic                 i2c;
    logic                 left_def;
    logic                 usb_prev;
    tcx_pkg::tcx_cfg_t    cfg;
    logic                 flip;
    tcx_pkg::tcx_route_t  route;
    tcx_pkg::tcx_sbu_t    sbu;
    tcx_pkg::tcx_gain_t   gain;
    tcx_pkg::tcx_ustate_t us;
    logic [CW-1:0]        det_cnt;
    logic [CW-1:0]        u1_cnt;
    tcx_pkg::tcx_phyctl_t phyctl;
    logic [6:0]           addr;
  } tcx_st_t;

  tcx_st_t    st_r;
  tcx_st_t    st_nxt;
  logic [2:0] pin_raw;
  logic [2:0] db;
  logic       usb_en;
  logic       both_det;
  logic       both_idle;
  logic       any_lfps;

  assign pin_raw = {orientation_pin, usb_enable_pin, dp_enable_pin};

  // Sync and debounce of dp, usb and orientation pins
  generate
    for (genvar i = 0; i < 3; i++)
    begin : g_db
      tcx_debounce #(
        .CW     (CW),
        .DB_CYC (DEB_CYC)
      ) u_db (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .pin     (pin_raw[i]),
        .level   (db[i])
      );
    end
  endgenerate

  function automatic tcx_pkg::tcx_route_t route_of(tcx_pkg::tcx_cfg_t c, logic f);
    tcx_pkg::tcx_route_t r;
    r = '0;
    if (c == tcx_pkg::cfg_usb || c == tcx_pkg::cfg_usb_dp2)
    begin
      r.host_rx = f ? tcx_pkg::hsrc_rx_b : tcx_pkg::hsrc_rx_a;
      if (f)
        r.tx_b = tcx_pkg::src_host_tx;
      else
        r.tx_a = tcx_pkg::src_host_tx;
    end
    if (c == tcx_pkg::cfg_dp4 || c == tcx_pkg::cfg_usb_dp2)
    begin
      if (f)
      begin
        r.rx_a = tcx_pkg::src_lane0;
        r.tx_a = tcx_pkg::src_lane1;
      end
      else
      begin
        r.rx_b = tcx_pkg::src_lane0;
        r.tx_b = tcx_pkg::src_lane1;
      end
    end
    if (c == tcx_pkg::cfg_dp4)
    begin
      if (f)
      begin
        r.tx_b = tcx_pkg::src_lane2;
        r.rx_b = tcx_pkg::src_lane3;
      end
      else
      begin
        r.tx_a = tcx_pkg::src_lane2;
        r.rx_a = tcx_pkg::src_lane3;
      end
    end
    return r;
  endfunction

  function automatic tcx_pkg::tcx_sbu_t sbu_of(logic dp, logic f, logic ovr);
    tcx_pkg::tcx_sbu_t s;
    s = '0;
    if (ovr || (dp && f))
    begin
      s.pos_b = 1'b1;
      s.neg_a = 1'b1;
    end
    else if (dp)
    begin
      s.pos_a = 1'b1;
      s.neg_b = 1'b1;
    end
    return s;
  endfunction

  assign usb_en = st_r.cfg == tcx_pkg::cfg_usb || st_r.cfg == tcx_pkg::cfg_usb_dp2;
  assign both_det = st_r.ph2.det_ufp & st_r.ph2.det_dfp;
  assign both_idle = st_r.ph2.idle_ufp & st_r.ph2.idle_dfp;
  assign any_lfps = st_r.ph2.lfps_ufp | st_r.ph2.lfps_dfp;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sp1 = strap_lvl;
    st_nxt.sp2 = st_r.sp1;
    st_nxt.ph1 = phy_stat;
    st_nxt.ph2 = st_r.ph1;
    st_nxt.phyctl.det_req = 1'b0;
    st_nxt.usb_prev = db[1];
    if (!st_r.pg)
    begin
      // Internal power-good after a fixed ramp count
      if (st_r.pg_cnt == CW'(PG_CYC - 1))
      begin
        st_nxt.pg = 1'b1;
        st_nxt.strap = st_r.sp2;
        st_nxt.i2c = st_r.sp2.host_sel != tcx_pkg::lv_0;
        st_nxt.addr = {ADDR_HI[st_r.sp2.disp_lo], st_r.sp2.ufp_lo};
        st_nxt.cfg = tcx_pkg::cfg_usb;
      end
      else
      begin
        st_nxt.pg_cnt = st_r.pg_cnt + 1'b1;
      end
    end
    else
    begin
      if (!st_r.pull_off)
      begin
        if (st_r.hold_cnt == CW'(HOLD_CYC - 1))
          st_nxt.pull_off = 1'b1;
        else
          st_nxt.hold_cnt = st_r.hold_cnt + 1'b1;
      end
      if (st_r.usb_prev && !db[1])
        st_nxt.left_def = 1'b1;
      if (st_r.i2c)
      begin
        st_nxt.cfg = tcx_pkg::tcx_cfg_t'({regs.dp_select_bit, regs.usb_select_bit});
        st_nxt.flip = regs.orientation_bit;
        st_nxt.sbu = sbu_of(regs.dp_select_bit, regs.orientation_bit,
                            regs.sideband_override_bit);
        st_nxt.gain = regs.gain;
      end
      else
      begin
        // Stays USB-only until the controller's low-high-low
        if (st_r.left_def)
          st_nxt.cfg = tcx_pkg::tcx_cfg_t'({db[0], db[1]});
        else
          st_nxt.cfg = tcx_pkg::cfg_usb;
        st_nxt.flip = db[2];
        // Debounced dp-enable low already exceeds 2 ms
        st_nxt.sbu = sbu_of(db[0], db[2], 1'b0);
        st_nxt.gain.dfp_a = {st_r.strap.dfp_hi, st_r.strap.dfp_lo};
        st_nxt.gain.dfp_b = {st_r.strap.dfp_hi, st_r.strap.dfp_lo};
        st_nxt.gain.ufp = {st_r.strap.ufp_hi, st_r.strap.ufp_lo};
        for (int i = 0; i < 4; i++)
          st_nxt.gain.lane[i] = {st_r.strap.disp_hi, st_r.strap.disp_lo};
      end
    end
    st_nxt.route = route_of(st_nxt.cfg, st_nxt.flip);

    // Link power machine
    if (!usb_en)
    begin
      st_nxt.us = tcx_pkg::us_disc;
      st_nxt.det_cnt = '0;
      st_nxt.u1_cnt = '0;
    end
    else
    begin
      unique case (st_r.us)
        tcx_pkg::us_disc:
        begin
          if (both_det)
            st_nxt.us = tcx_pkg::us_u0;
        end
        tcx_pkg::us_u0:
        begin
          st_nxt.u1_cnt = '0;
          if (both_idle)
            st_nxt.us = tcx_pkg::us_u1;
        end
        tcx_pkg::us_u1:
        begin
          if (any_lfps || !both_idle)
            st_nxt.us = tcx_pkg::us_u0;
          else if (st_r.u1_cnt == CW'(U1_CYC - 1))
            st_nxt.us = tcx_pkg::us_u23;
          else
            st_nxt.u1_cnt = st_r.u1_cnt + 1'b1;
        end
        tcx_pkg::us_u23:
        begin
          if (!both_det)
            st_nxt.us = tcx_pkg::us_disc;
          else if (any_lfps)
            st_nxt.us = tcx_pkg::us_u0;
        end
      endcase
      if (st_r.us == tcx_pkg::us_disc || st_r.us == tcx_pkg::us_u23)
      begin
        if (st_r.det_cnt == CW'(RXDET_CYC - 1))
        begin
          st_nxt.phyctl.det_req = 1'b1;
          st_nxt.det_cnt = '0;
        end
        else
        begin
          st_nxt.det_cnt = st_r.det_cnt + 1'b1;
        end
      end
      else
      begin
        st_nxt.det_cnt = '0;
      end
    end
    st_nxt.phyctl.term_en = st_nxt.us != tcx_pkg::us_disc;
    st_nxt.phyctl.tx_cm_en = st_nxt.us == tcx_pkg::us_u0 || st_nxt.us == tcx_pkg::us_u1;
    st_nxt.phyctl.redrive_en = st_nxt.us == tcx_pkg::us_u0;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign power_good = st_r.pg;
  assign strap_pull_off = st_r.pull_off;
  assign i2c_mode = st_r.i2c;
  assign cfg = st_r.cfg;
  assign flipped = st_r.flip;
  assign route = st_r.route;
  assign sbu = st_r.sbu;
  assign gain = st_r.gain;
  assign usb_state = st_r.us;
  assign phyctl = st_r.phyctl;
  assign target_addr = st_r.addr;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  property p_pull_iso;
    $rose(st_r.pull_off) |-> st_r.pg && $past(st_r.hold_cnt) == CW'(HOLD_CYC - 1);
  endproperty
  a_pull_iso: assert property (p_pull_iso) else $error("pulls isolated early");

  property p_pin_mode;
    $rose(st_r.pg) |-> st_r.i2c == (st_r.strap.host_sel != tcx_pkg::lv_0);
  endproperty
  a_pin_mode: assert property (p_pin_mode) else $error("mode strap misread");

  property p_usb_start;
    $rose(st_r.pg) |-> st_r.cfg == tcx_pkg::cfg_usb;
  endproperty
  a_usb_start: assert property (p_usb_start) else $error("not usb-only at start");

  property p_pin_decode;
    st_r.pg && !st_r.i2c && st_r.left_def |=> st_r.cfg == tcx_pkg::tcx_cfg_t'($past({db[0], db[1]}));
  endproperty
  a_pin_decode: assert property (p_pin_decode) else $error("pin decode wrong");

  property p_sbu_open;
    st_r.pg && !st_r.i2c && !db[0] |=> st_r.sbu == '0;
  endproperty
  a_sbu_open: assert property (p_sbu_open) else $error("sideband not open");

  property p_usb_route;
    st_r.cfg == tcx_pkg::cfg_usb && !st_r.flip |-> st_r.route.host_rx == tcx_pkg::hsrc_rx_a
      && st_r.route.tx_a == tcx_pkg::src_host_tx;
  endproperty
  a_usb_route: assert property (p_usb_route) else $error("usb route wrong");

  property p_dp4_flip;
    st_r.cfg == tcx_pkg::cfg_dp4 && st_r.flip |-> st_r.route.rx_a == tcx_pkg::src_lane0
      && st_r.route.tx_b == tcx_pkg::src_lane2 && st_r.route.rx_b == tcx_pkg::src_lane3;
  endproperty
  a_dp4_flip: assert property (p_dp4_flip) else $error("dp4 flipped route wrong");

  property p_sbu_ovr;
    st_r.pg && st_r.i2c && regs.sideband_override_bit |=> st_r.sbu.pos_b && st_r.sbu.neg_a;
  endproperty
  a_sbu_ovr: assert property (p_sbu_ovr) else $error("override not applied");

  property p_disc_exit;
    usb_en && st_r.us == tcx_pkg::us_disc && both_det |=> st_r.us == tcx_pkg::us_u0;
  endproperty
  a_disc_exit: assert property (p_disc_exit) else $error("no exit to U0");

  property p_u0_idle;
    usb_en && st_r.us == tcx_pkg::us_u0 && both_idle |=> st_r.us == tcx_pkg::us_u1;
  endproperty
  a_u0_idle: assert property (p_u0_idle) else $error("no U1 entry");

  property p_u23_lost;
    usb_en && st_r.us == tcx_pkg::us_u23 && !both_det |=> st_r.us == tcx_pkg::us_disc
      ##0 !st_r.phyctl.term_en;
  endproperty
  a_u23_lost: assert property (p_u23_lost) else $error("no disconnect");

  property p_det_pulse;
    st_r.phyctl.det_req |=> !st_r.phyctl.det_req [*2];
  endproperty
  a_det_pulse: assert property (p_det_pulse) else $error("detect not a pulse");

  c_u0: cover property (st_r.us == tcx_pkg::us_disc ##1 st_r.us == tcx_pkg::us_u0);
  c_dp4f: cover property (st_r.cfg == tcx_pkg::cfg_dp4 && st_r.flip);
  c_ovr: cover property (st_r.i2c && st_r.sbu.pos_b && !st_r.flip);
  c_u23: cover property (st_r.us == tcx_pkg::us_u23 ##1 st_r.us == tcx_pkg::us_disc);
endmodule

// File: tcx_pdc_model.sv
// Port controller model driving the dp enable, usb enable and orientation pins
`timescale 1ns/100ps
module tcx_pdc_model #(
  parameter int HOLD_CYC = 20,
  parameter int OVL_CYC  = 1000
) (
  input  wire logic              mclk,
  input  wire tcx_pkg::tcx_cfg_t mode,
  input  wire logic              flip,
  input  wire logic              go,
  input  wire logic [1:0]        act,
  output logic                   dp_enable_pin,
  output logic                   usb_enable_pin,
  output logic                   orientation_pin,
  output logic                   busy
);
  // act 0: set mode, 1: leave USB-only, 2: short glitch on dp enable
  initial
  begin
    dp_enable_pin = 1'b0;
    usb_enable_pin = 1'b0;
    orientation_pin = 1'b0;
    busy = 1'b0;
    forever
    begin
      @(posedge mclk);
      if (go)
      begin
        busy <= 1'b1;
        if (act == 2'h1)
        begin
          usb_enable_pin <= 1'b0;
          repeat (HOLD_CYC) @(posedge mclk);
          usb_enable_pin <= 1'b1;
          repeat (HOLD_CYC) @(posedge mclk);
          usb_enable_pin <= 1'b0;
          repeat (HOLD_CYC) @(posedge mclk);
        end
        else if (act == 2'h2)
        begin
          dp_enable_pin <= !dp_enable_pin;
          repeat (3) @(posedge mclk);
          dp_enable_pin <= !dp_enable_pin;
          repeat (HOLD_CYC) @(posedge mclk);
        end
        else
        begin
          if ((mode == tcx_pkg::cfg_dp4 && !dp_enable_pin && usb_enable_pin) ||
              (mode == tcx_pkg::cfg_usb && dp_enable_pin && !usb_enable_pin))
          begin
            dp_enable_pin <= 1'b1;
            usb_enable_pin <= 1'b1;
            repeat (OVL_CYC) @(posedge mclk);
          end
          dp_enable_pin <= mode[1];
          usb_enable_pin <= mode[0];
          orientation_pin <= flip;
          repeat (HOLD_CYC) @(posedge mclk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule

// File: tb_tcx_crossbar_ctl.sv
// Self-checking bench for the crossbar configuration block
`timescale 1ns/100ps
module tb_tcx_crossbar_ctl;
  logic                 mclk = 1'b0;
  logic                 sys_rst = 1'b1;
  logic                 dp_pin, usb_pin, ori_pin, busy, go = 1'b0, flip = 1'b0;
  logic [1:0]           act = 2'h0;
  tcx_pkg::tcx_cfg_t    mode = tcx_pkg::cfg_off;
  tcx_pkg::tcx_straps_t straps, sl;
  tcx_pkg::tcx_reg_t    regs = '0;
  tcx_pkg::tcx_phy_t    phy = '0;
  logic                 power_good, strap_pull_off, i2c_mode, flipped;
  tcx_pkg::tcx_cfg_t    cfg;
  tcx_pkg::tcx_route_t  route;
  tcx_pkg::tcx_sbu_t    sbu;
  tcx_pkg::tcx_gain_t   gain;
  tcx_pkg::tcx_ustate_t usb_state;
  tcx_pkg::tcx_phyctl_t phyctl;
  logic [6:0]           target_addr;
  int                   bad_count = 0;
  int                   n_tests = 0;
  int                   k, n;

  always #2 mclk = ~mclk;

  tcx_crossbar_ctl #(.PG_CYC(20), .DEB_CYC(8), .RXDET_CYC(16), .U1_CYC(10)) i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .dp_enable_pin(dp_pin), .usb_enable_pin(usb_pin),
    .orientation_pin(ori_pin), .strap_lvl(straps), .regs(regs), .phy_stat(phy),
    .power_good(power_good), .strap_pull_off(strap_pull_off), .i2c_mode(i2c_mode), .cfg(cfg),
    .flipped(flipped), .route(route), .sbu(sbu), .gain(gain), .usb_state(usb_state),
    .phyctl(phyctl), .target_addr(target_addr));

  tcx_pdc_model i_pdc (
    .mclk(mclk), .mode(mode), .flip(flip), .go(go), .act(act), .dp_enable_pin(dp_pin),
    .usb_enable_pin(usb_pin), .orientation_pin(ori_pin), .busy(busy));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // One clock, then sample once the outputs have settled
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic tcx_pkg::tcx_route_t exp_route(input tcx_pkg::tcx_cfg_t c, input logic f);
    tcx_pkg::tcx_route_t r;
    r = '0;
    if (c[0])
    begin
      r.host_rx = f ? tcx_pkg::hsrc_rx_b : tcx_pkg::hsrc_rx_a;
      if (f)
        r.tx_b = tcx_pkg::src_host_tx;
      else
        r.tx_a = tcx_pkg::src_host_tx;
    end
    if (c[1] && f)
    begin
      r.rx_a = tcx_pkg::src_lane0;
      r.tx_a = tcx_pkg::src_lane1;
    end
    if (c[1] && !f)
    begin
      r.rx_b = tcx_pkg::src_lane0;
      r.tx_b = tcx_pkg::src_lane1;
    end
    if (c == tcx_pkg::cfg_dp4 && f)
    begin
      r.tx_b = tcx_pkg::src_lane2;
      r.rx_b = tcx_pkg::src_lane3;
    end
    if (c == tcx_pkg::cfg_dp4 && !f)
    begin
      r.tx_a = tcx_pkg::src_lane2;
      r.rx_a = tcx_pkg::src_lane3;
    end
    return r;
  endfunction

  function automatic tcx_pkg::tcx_sbu_t exp_sbu(input logic dp, input logic f, input logic ovr);
    tcx_pkg::tcx_sbu_t s;
    s = '0;
    if (ovr || (dp && f))
      {s.pos_b, s.neg_a} = 2'h3;
    else if (dp)
      {s.pos_a, s.neg_b} = 2'h3;
    return s;
  endfunction

  function automatic tcx_pkg::tcx_gain_t exp_gain(input tcx_pkg::tcx_straps_t s);
    tcx_pkg::tcx_gain_t g;
    g.dfp_a = {s.dfp_hi, s.dfp_lo};
    g.dfp_b = {s.dfp_hi, s.dfp_lo};
    g.ufp = {s.ufp_hi, s.ufp_lo};
    g.lane = {4{s.disp_hi, s.disp_lo}};
    return g;
  endfunction

  task automatic chk_mode(input tcx_pkg::tcx_cfg_t c, input logic f, input logic ovr);
    chk("cfg", cfg, c);
    chk("flipped", flipped, f);
    chk("route", route, exp_route(c, f));
    chk("sbu", sbu, exp_sbu(c[1], f, ovr));
  endtask

  task automatic pins(input tcx_pkg::tcx_cfg_t c, input logic f, input logic [1:0] a);
    @(posedge mclk);
    go <= 1'b1;
    mode <= c;
    flip <= f;
    act <= a;
    @(posedge mclk);
    go <= 1'b0;
    tick();
    for (k = 0; k < 2000 && busy !== 1'b0; k++)
      tick();
    chk("pdc_done", busy, 1'b0);
    repeat (16) @(posedge mclk);
    #1;
  endtask

  task automatic do_reset();
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk("rst_out", {power_good, cfg, usb_state, route, sbu}, '0);
    for (k = 1; k < 40 && power_good !== 1'b1; k++)
      tick();
    chk("pg_late", k <= 22, 1'b1);
    chk("pull_off_early", strap_pull_off, 1'b0);
    chk("cfg_start", cfg, tcx_pkg::cfg_usb);
  endtask

  task automatic link(input logic [5:0] p, input tcx_pkg::tcx_ustate_t s, input logic [2:0] pc);
    @(posedge mclk);
    phy <= p;
    repeat (3) @(posedge mclk);
    #1;
    chk("usb_state", usb_state, s);
    chk("phyctl", phyctl[3:1], pc);
  endtask

  task automatic count_req(input tcx_pkg::tcx_ustate_t s);
    for (k = 0; k < 30 && usb_state !== s; k++)
      tick();
    chk("wait_state", usb_state, s);
    n = 0;
    // Two whole detect periods, whatever the phase
    repeat (32)
    begin
      @(posedge mclk);
      #1;
      n += int'(phyctl.det_req === 1'b1);
    end
  endtask

  initial
  begin
    repeat (60000) @(posedge mclk);
    bad_count++;
    print_verdict();
  end

  initial
  begin
    straps = {tcx_pkg::lv_0, tcx_pkg::lv_r, tcx_pkg::lv_f, tcx_pkg::lv_1, tcx_pkg::lv_0,
              tcx_pkg::lv_0, tcx_pkg::lv_1};
    sl = straps;
    do_reset();
    chk("i2c_mode", i2c_mode, 1'b0);
    chk("addr", target_addr, 7'h0c);
    tick();
    chk("gain", gain, exp_gain(sl));
    straps.dfp_lo <= tcx_pkg::lv_1;
    for (k = 0; k < 2600 && strap_pull_off !== 1'b1; k++)
      tick();
    chk("pull_off", k >= 2490 && k <= 2510, 1'b1);
    chk("gain_held", gain, exp_gain(sl));
    chk_mode(tcx_pkg::cfg_usb, 1'b0, 1'b0);
    pins(tcx_pkg::cfg_off, 1'b0, 2'h1);
    chk_mode(tcx_pkg::cfg_off, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      pins(tcx_pkg::tcx_cfg_t'(i[2:1]), i[0], 2'h0);
      chk_mode(tcx_pkg::tcx_cfg_t'(i[2:1]), i[0], 1'b0);
    end
    pins(tcx_pkg::cfg_usb_dp2, 1'b1, 2'h2);
    chk_mode(tcx_pkg::cfg_usb_dp2, 1'b1, 1'b0);
    pins(tcx_pkg::cfg_usb, 1'b0, 2'h0);
    link(6'h30, tcx_pkg::us_u0, 3'h7);
    link(6'h3c, tcx_pkg::us_u1, 3'h6);
    link(6'h3d, tcx_pkg::us_u0, 3'h7);
    link(6'h3c, tcx_pkg::us_u1, 3'h6);
    count_req(tcx_pkg::us_u23);
    chk("phyctl_u23", phyctl[3:1], 3'h4);
    chk("det_req_u23", n, 2);
    link(6'h3e, tcx_pkg::us_u0, 3'h7);
    link(6'h3c, tcx_pkg::us_u1, 3'h6);
    count_req(tcx_pkg::us_u23);
    link(6'h2c, tcx_pkg::us_disc, 3'h0);
    count_req(tcx_pkg::us_disc);
    chk("det_req", n, 2);
    phy <= 6'h30;
    pins(tcx_pkg::cfg_off, 1'b0, 2'h0);
    chk("usb_state_off", usb_state, tcx_pkg::us_disc);
    straps.host_sel <= tcx_pkg::lv_r;
    straps.ufp_lo <= tcx_pkg::lv_f;
    straps.disp_lo <= tcx_pkg::lv_r;
    do_reset();
    chk("i2c_mode", i2c_mode, 1'b1);
    chk("addr_i2c", target_addr, 7'h22);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge mclk);
      {regs.sideband_override_bit, regs.orientation_bit, regs.dp_select_bit, regs.usb_select_bit} <= i[3:0];
      regs.gain <= {7{i[3:0]}};
      @(posedge mclk);
      #1;
      chk_mode(tcx_pkg::tcx_cfg_t'(i[1:0]), i[2], i[3]);
      chk("sbu_i2c", sbu, exp_sbu(i[1], i[2], i[3]));
      chk("gain_i2c", gain, {7{i[3:0]}});
    end
    print_verdict();
  end
endmodule
